// ### sla_pkg.sv
// Package with constants and types for the slave status indicator and node address block
// What this block does
// - Each port's link indicator is dark without a physical link and lit while the link is up.
// - A port's link indicator flickers while its link is up and traffic passes through it.
// - Run indicator: off in Init, blinks in Pre-Op, single flash in Safe-Op, on in Op.
// - Error indicator: off, blink, single, double flash, flicker or on by error class.
// - The switch address is ten times the left digit plus the right digit, from 00 to 99.
// - With both switches at 00 the host-assigned address is used.
// - With a host from another maker the host-assigned address is always used.
// - With the own-make host and switches at 01 to 99 the switch value is reported.
// - The switches are sampled once after each reset release and held until the next reset.
// - A duplicated node address raises an error and stops operation.
package sla_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned FLICKER_MS_X10 = 500;
  localparam int unsigned BLINK_MS = 200;
  localparam int unsigned FLASH_OFF_MS = 1000;
  localparam int unsigned FLICKER_CYC = (FLICKER_MS_X10 * CLK_MHZ) / 10;
  localparam int unsigned BLINK_CYC = BLINK_MS * 1000 * CLK_MHZ;
  localparam int unsigned FLASH_OFF_CYC = FLASH_OFF_MS * 1000 * CLK_MHZ;
  localparam int unsigned SAMPLE_DELAY_CYC = 16;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [6:0] ADDR_MAX = 7'h63;
  localparam int unsigned CNT_W = 32;

  typedef enum logic [1:0] {
    SLA_ST_INIT,
    SLA_ST_PREOP,
    SLA_ST_SAFEOP,
    SLA_ST_OP
  } sla_state_type;

  typedef enum logic [2:0] {
    SLA_PAT_OFF,
    SLA_PAT_BLINK,
    SLA_PAT_SINGLE,
    SLA_PAT_DOUBLE,
    SLA_PAT_FLICKER,
    SLA_PAT_ON
  } sla_pattern_type;

  // Error inputs bit order: 0 setting,1 sync/data,2 app watchdog,3 boot,4 pdi watchdog,5 dup
  localparam int unsigned ERR_N = 6;
  localparam logic [17:0] ERR_PRIO_DEFAULT = {3'd0, 3'd1, 3'd2, 3'd3, 3'd4, 3'd5};
endpackage

// ### sla_pattern_gen.sv
// Pattern timebase producing blink, flash and flicker levels
`timescale 1ns/1ps
module sla_pattern_gen
  import sla_pkg::*;
#(
  parameter int unsigned FLICKER_C = FLICKER_CYC,
  parameter int unsigned BLINK_C = BLINK_CYC,
  parameter int unsigned FLASH_OFF_C = FLASH_OFF_CYC
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  output logic flicker_o,
  output logic blink_o,
  output logic single_o,
  output logic double_o
);
  logic [CNT_W-1:0] fl_cnt, next_fl_cnt;
  logic [CNT_W-1:0] bl_cnt, next_bl_cnt;
  logic [2:0] phase, next_phase;
  logic fl, next_fl;
  logic bl, next_bl;
  logic sg, next_sg;
  logic db, next_db;

  // Phases: 0 on,1 off,2 on,3..6 long off; each phase one blink on or off time, so long off lasts four
  always_comb begin
    next_fl_cnt = fl_cnt + 1'b1;
    next_fl = fl;
    if (fl_cnt >= CNT_W'(FLICKER_C - 1)) begin
      next_fl_cnt = '0;
      next_fl = ~fl;
    end
    next_bl_cnt = bl_cnt + 1'b1;
    next_bl = bl;
    next_phase = phase;
    if (bl_cnt >= CNT_W'(BLINK_C - 1)) begin
      next_bl_cnt = '0;
      next_bl = ~bl;
      next_phase = (phase == 3'd6) ? 3'd0 : phase + 3'd1;
    end
    next_sg = (next_phase == 3'd0);
    next_db = (next_phase == 3'd0) || (next_phase == 3'd2);
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fl_cnt <= '0;
      bl_cnt <= '0;
      phase <= 3'd0;
      fl <= 1'b0;
      bl <= 1'b0;
      sg <= 1'b0;
      db <= 1'b0;
    end else begin
      fl_cnt <= next_fl_cnt;
      bl_cnt <= next_bl_cnt;
      phase <= next_phase;
      fl <= next_fl;
      bl <= next_bl;
      sg <= next_sg;
      db <= next_db;
    end
  end

  assign flicker_o = fl;
  assign blink_o = bl;
  assign single_o = sg;
  assign double_o = db;
endmodule

// ### sla_status_led.sv
// Status indicators and node address selection of the fieldbus slave
`timescale 1ns/1ps
module sla_status_led
  import sla_pkg::*;
#(
  parameter int unsigned FLICKER_C = FLICKER_CYC,
  parameter int unsigned BLINK_C = BLINK_CYC,
  parameter int unsigned FLASH_OFF_C = FLASH_OFF_CYC,
  parameter logic [17:0] ERR_PRIO = sla_pkg::ERR_PRIO_DEFAULT
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [1:0] link_up_i,
  input wire logic [1:0] traffic_i,
  input wire sla_pkg::sla_state_type slave_state_i,
  input wire logic [4:0] error_i,
  input wire logic [3:0] switch_tens_i,
  input wire logic [3:0] switch_units_i,
  input wire logic own_host_i,
  input wire logic [6:0] host_address_i,
  input wire logic dup_address_i,
  output logic [1:0] link_led_o,
  output logic run_led_o,
  output logic err_led_o,
  output logic [6:0] node_address_o,
  output logic address_valid_o,
  output logic halt_o
);
  import sla_pkg::*;

  logic flicker, blink, single, dbl;

  sla_pattern_gen #(
    .FLICKER_C(FLICKER_C),
    .BLINK_C(BLINK_C),
    .FLASH_OFF_C(FLASH_OFF_C)
  ) u_pat (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .flicker_o(flicker),
    .blink_o(blink),
    .single_o(single),
    .double_o(dbl)
  );

  // Level of one pattern for the current timebase state
  function automatic logic pat_level(input sla_pattern_type p, input logic fl, input logic bl,
                                     input logic sg, input logic db);
    logic r;
    r = 1'b0;
    case (p)
      SLA_PAT_OFF: r = 1'b0;
      SLA_PAT_BLINK: r = bl;
      SLA_PAT_SINGLE: r = sg;
      SLA_PAT_DOUBLE: r = db;
      SLA_PAT_FLICKER: r = fl;
      SLA_PAT_ON: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Digits above nine read as nine
  function automatic logic [3:0] clamp_digit(input logic [3:0] d);
    return (d > 4'h9) ? 4'h9 : d;
  endfunction

  // Switch sampling and address
  logic [4:0] smp_cnt, next_smp_cnt;
  logic sampled, next_sampled;
  logic [6:0] sw_addr, next_sw_addr;
  logic [6:0] addr, next_addr;
  logic stopped, next_stopped;
  logic [1:0] link_led, next_link_led;
  logic run_led, next_run_led;
  logic err_led, next_err_led;
  sla_pattern_type run_pat, err_pat;
  logic [ERR_N-1:0] err_vec;

  always_comb begin
    next_smp_cnt = smp_cnt;
    next_sampled = sampled;
    next_sw_addr = sw_addr;
    if (!sampled) begin
      next_smp_cnt = smp_cnt + 5'd1;
      if (smp_cnt == 5'(SAMPLE_DELAY_CYC - 1)) begin
        next_sampled = 1'b1;
        next_sw_addr = 7'(clamp_digit(switch_tens_i) * 4'd10) +
                       7'(clamp_digit(switch_units_i));
      end
    end
    if (!sampled || sw_addr == 7'h00 || !own_host_i) begin
      next_addr = host_address_i;
    end else begin
      next_addr = sw_addr;
    end
    next_stopped = stopped | (sampled & dup_address_i);
  end

  // Indicator pattern selection
  always_comb begin
    case (slave_state_i)
      SLA_ST_INIT: run_pat = SLA_PAT_OFF;
      SLA_ST_PREOP: run_pat = SLA_PAT_BLINK;
      SLA_ST_SAFEOP: run_pat = SLA_PAT_SINGLE;
      SLA_ST_OP: run_pat = SLA_PAT_ON;
      default: run_pat = SLA_PAT_OFF;
    endcase
    err_vec = {stopped, error_i};
    err_pat = SLA_PAT_OFF;
    // Lowest priority first so the highest priority one wins
    for (int p = 0; p < ERR_N; p++) begin
      for (int i = 0; i < ERR_N; i++) begin
        if (ERR_PRIO[3*i +: 3] == 3'(p) && err_vec[i]) begin
          case (i)
            0: err_pat = SLA_PAT_BLINK;
            1: err_pat = SLA_PAT_SINGLE;
            2: err_pat = SLA_PAT_DOUBLE;
            3: err_pat = SLA_PAT_FLICKER;
            4: err_pat = SLA_PAT_ON;
            default: err_pat = SLA_PAT_BLINK; // Duplicate address shown as setting error
          endcase
        end
      end
    end
    for (int k = 0; k < 2; k++) begin
      next_link_led[k] = link_up_i[k] & (traffic_i[k] ? flicker : 1'b1);
    end
    next_run_led = stopped ? 1'b0 : pat_level(run_pat, flicker, blink, single, dbl);
    next_err_led = pat_level(err_pat, flicker, blink, single, dbl);
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      smp_cnt <= '0;
      sampled <= 1'b0;
      sw_addr <= ADDR_RESET;
      addr <= ADDR_RESET;
      stopped <= 1'b0;
      link_led <= 2'h0;
      run_led <= 1'b0;
      err_led <= 1'b0;
    end else begin
      smp_cnt <= next_smp_cnt;
      sampled <= next_sampled;
      sw_addr <= next_sw_addr;
      addr <= next_addr;
      stopped <= next_stopped;
      link_led <= next_link_led;
      run_led <= next_run_led;
      err_led <= next_err_led;
    end
  end

  assign link_led_o = link_led;
  assign run_led_o = run_led;
  assign err_led_o = err_led;
  assign node_address_o = addr;
  assign address_valid_o = sampled;
  assign halt_o = stopped;

  // Checks
  link_dark_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    !link_up_i[0] |=> !link_led_o[0]) else $error("link led lit without link");
  link_on_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    link_up_i[1] && !traffic_i[1] |=> link_led_o[1]) else $error("link led dark with link");
  link_flick_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    link_up_i[0] && traffic_i[0] |=> link_led_o[0] == $past(flicker)) else $error("no flicker");
  run_op_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    slave_state_i == SLA_ST_OP && !stopped |=> run_led_o) else $error("run led not on in op");
  run_init_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    slave_state_i == SLA_ST_INIT |=> !run_led_o) else $error("run led lit in init");
  err_none_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    error_i == 5'h00 && !stopped |=> !err_led_o) else $error("error led lit without error");
  err_pdi_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    error_i == 5'h10 |=> err_led_o) else $error("pdi watchdog not shown steady");
  err_sync_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    error_i == 5'h02 |=> err_led_o == $past(single)) else $error("sync error not single flash");
  err_app_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    error_i == 5'h04 |=> err_led_o == $past(dbl)) else $error("app watchdog not double flash");
  err_boot_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    error_i == 5'h08 |=> err_led_o == $past(flicker)) else $error("boot error not flickering");
  // Setting error carries the top code in the default priority order
  err_set_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    ERR_PRIO == ERR_PRIO_DEFAULT && error_i[0] |=> err_led_o == $past(blink))
    else $error("setting error not shown first");
  run_pre_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    slave_state_i == SLA_ST_PREOP && !stopped |=> run_led_o == $past(blink))
    else $error("run led not blinking in pre-op");
  run_safe_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    slave_state_i == SLA_ST_SAFEOP && !stopped |=> run_led_o == $past(single))
    else $error("run led not single flashing in safe-op");
  run_halt_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    stopped |=> !run_led_o) else $error("run led lit after halt");
  halt_keep_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    halt_o |=> halt_o) else $error("halt released without reset");
  out_dark_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    !link_up_i[1] |=> !link_led_o[1]) else $error("out link led lit without link");
  out_flick_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    link_up_i[1] && traffic_i[1] |=> link_led_o[1] == $past(flicker)) else $error("no flicker");
  addr_hold_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    sampled |=> sampled && $stable(sw_addr)) else $error("switch value changed after sample");
  addr_range_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    sampled |-> sw_addr <= ADDR_MAX) else $error("switch address out of range");
  addr_host_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    !own_host_i |=> node_address_o == $past(host_address_i)) else $error("host address ignored");
  addr_zero_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    sampled && sw_addr == 7'h00 |=> node_address_o == $past(host_address_i))
    else $error("host address not used with switches at zero");
  addr_sw_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    sampled && own_host_i && sw_addr != 7'h00 |=> node_address_o == $past(sw_addr))
    else $error("switch address not used");
  dup_stop_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    sampled && dup_address_i |=> halt_o ##1 halt_o) else $error("duplicate address not halted");

  // Cover points for the main scenarios
  cov_op_c: cover property (@(posedge clock_i) disable iff (!reset_n_i)
    slave_state_i == SLA_ST_OP ##1 run_led_o);
  cov_traffic_c: cover property (@(posedge clock_i) disable iff (!reset_n_i)
    link_led_o[0] ##1 !link_led_o[0] ##1 link_led_o[0]);
  cov_dup_c: cover property (@(posedge clock_i) disable iff (!reset_n_i) $rose(halt_o));
  cov_prio_c: cover property (@(posedge clock_i) disable iff (!reset_n_i)
    error_i[0] && error_i[4] ##1 err_led_o);
  cov_host_c: cover property (@(posedge clock_i) disable iff (!reset_n_i)
    sampled && !own_host_i ##1 node_address_o != 7'h00);
endmodule

// ### sla_host_model.sv
// Behavioural model of the network host controller feeding address and status
`timescale 1ns/1ps
module sla_host_model (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic own_make_i,
  input wire logic [6:0] assign_addr_i,
  input wire logic dup_seen_i,
  output logic own_host_o,
  output logic [6:0] host_address_o,
  output logic dup_address_o
);
  // Host answers one cycle after its own decision, as a registered source
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      own_host_o <= 1'b0;
      host_address_o <= 7'h00;
      dup_address_o <= 1'b0;
    end else begin
      own_host_o <= own_make_i;
      host_address_o <= assign_addr_i;
      dup_address_o <= dup_seen_i;
    end
  end
endmodule

// ### testbench.sv
// Self-checking bench for the status indicator and node address block
`timescale 1ns/1ps
module testbench;
  import sla_pkg::*;
  logic clock_i;
  logic reset_n_i = 1'b0;
  logic [1:0] link_up_i = 2'b00;
  logic [1:0] traffic_i = 2'b00;
  sla_state_type slave_state_i = SLA_ST_INIT;
  logic [4:0] error_i = 5'h00;
  logic [3:0] switch_tens_i = 4'h0;
  logic [3:0] switch_units_i = 4'h0;
  logic own_make = 1'b0;
  logic dup_seen = 1'b0;
  logic [6:0] assign_addr = 7'h00;
  logic own_host_i, dup_address_i, err_led_o, run_led_o, address_valid_o, halt_o;
  logic [6:0] host_address_i, node_address_o;
  logic [1:0] link_led_o;
  int err_count = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'he043;
  logic [7:0] exp_q[$];
  logic [7:0] obs;
  event got;
  logic [7:0] run_cls[4] = '{8'h00, 8'h02, 8'h02, 8'h01};
  logic [4:0] err_in[8] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h11, 5'h18};
  logic [7:0] err_cls[8] = '{8'h00, 8'h02, 8'h02, 8'h02, 8'h02, 8'h01, 8'h02, 8'h02};

  sla_host_model i_sla_host_model (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .own_make_i(own_make), .assign_addr_i(assign_addr), .dup_seen_i(dup_seen),
    .own_host_o(own_host_i), .host_address_o(host_address_i), .dup_address_o(dup_address_i));

  sla_status_led #(.FLICKER_C(4), .BLINK_C(8), .FLASH_OFF_C(8)) i_sla_status_led (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .link_up_i(link_up_i), .traffic_i(traffic_i),
    .slave_state_i(slave_state_i), .error_i(error_i), .switch_tens_i(switch_tens_i),
    .switch_units_i(switch_units_i), .own_host_i(own_host_i), .host_address_i(host_address_i),
    .dup_address_i(dup_address_i), .link_led_o(link_led_o), .run_led_o(run_led_o),
    .err_led_o(err_led_o), .node_address_o(node_address_o),
    .address_valid_o(address_valid_o), .halt_o(halt_o));

  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // Classify an indicator over n cycles: 0 dark, 1 steady, 2 changing
  task automatic watch(input int sel, input int n, input logic [7:0] cls);
    int ones;
    logic v;
    logic unk;
    ones = 0;
    unk = 1'b0;
    step(3);
    repeat (n) begin
      v = (sel == 2) ? run_led_o : (sel == 3) ? err_led_o : (sel == 4) ? halt_o : link_led_o[sel];
      if (v === 1'b1) ones++;
      if ($isunknown(v)) unk = 1'b1;
      step(1);
    end
    exp_q.push_back(cls);
    obs = unk ? 8'hff : (ones == 0) ? 8'h00 : (ones == n) ? 8'h01 : 8'h02;
    ->got;
  endtask

  task automatic addr_chk(input logic [6:0] a);
    step(3);
    exp_q.push_back({1'b1, a});
    obs = {address_valid_o, node_address_o};
    ->got;
  endtask

  task automatic do_reset();
    reset_n_i = 1'b0;
    step(12);
    reset_n_i = 1'b1;
    for (int i = 0; i < 40 && address_valid_o !== 1'b1; i++) step(1);
  endtask

  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(got) begin
    n_compared++;
    if (obs !== exp_q[0]) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, obs, exp_q[0]);
    end
    void'(exp_q.pop_front());
  end

  initial begin
    #100000;
    err_count++;
    test_done();
  end

  initial begin
    switch_tens_i = 4'h4;
    switch_units_i = 4'h2;
    own_make = 1'b1;
    seed = lfsr(seed);
    assign_addr = seed[6:0];
    do_reset();
    addr_chk(7'h2a);
    switch_tens_i = 4'h7;
    switch_units_i = 4'h3;
    addr_chk(7'h2a);
    own_make = 1'b0;
    addr_chk(assign_addr);
    own_make = 1'b1;
    switch_tens_i = 4'h0;
    switch_units_i = 4'h0;
    seed = lfsr(seed);
    assign_addr = seed[6:0];
    do_reset();
    addr_chk(assign_addr);
    $display("address tests done");
    watch(0, 20, 8'h00);
    link_up_i = 2'b11;
    watch(1, 20, 8'h01);
    traffic_i = 2'b01;
    watch(0, 40, 8'h02);
    watch(1, 20, 8'h01);
    $display("link tests done");
    for (int s = 0; s < 4; s++) begin
      slave_state_i = sla_state_type'(s);
      watch(2, 150, run_cls[s]);
    end
    $display("run tests done");
    for (int e = 0; e < 8; e++) begin
      error_i = err_in[e];
      watch(3, 150, err_cls[e]);
    end
    error_i = 5'h00;
    $display("error tests done");
    dup_seen = 1'b1;
    step(4);
    dup_seen = 1'b0;
    watch(4, 20, 8'h01);
    watch(2, 20, 8'h00);
    watch(3, 150, 8'h02);
    $display("duplicate address test done");
    step(2);
    test_done();
  end
endmodule
